// ---- core/cpc_pkg.sv ----
// Constants, register map and carrier types of the counter preset and compare block.
// Assumes a single 25 MHz clock domain and a plain strobe register port.
package cpc_pkg;
  localparam int unsigned CPC_CNT_W = 32;
  localparam int unsigned CPC_ADDR_W = 8;
  localparam int unsigned CPC_DATA_W = 32;
  localparam int unsigned CPC_NPOINTS = 2;

  localparam logic [7:0] CPC_OFS_CTRL = 8'h00;
  localparam logic [7:0] CPC_OFS_PRESET = 8'h04;
  localparam logic [7:0] CPC_OFS_CMP1 = 8'h08;
  localparam logic [7:0] CPC_OFS_CMP2 = 8'h0c;
  localparam logic [7:0] CPC_OFS_COUNT_LOW = 8'h10;
  localparam logic [7:0] CPC_OFS_COUNT_HIGH = 8'h14;
  localparam logic [7:0] CPC_OFS_FLAGS = 8'h18;
  localparam logic [7:0] CPC_OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] CPC_OFS_IRQ_MASK = 8'h20;

  // Control register fields.
  localparam int unsigned CPC_CTRL_COUNT_EN = 0;
  localparam int unsigned CPC_CTRL_PRESET = 1;
  localparam int unsigned CPC_CTRL_OUT_EN = 2;
  localparam int unsigned CPC_CTRL_RST1 = 3;
  localparam int unsigned CPC_CTRL_RST2 = 4;
  localparam int unsigned CPC_CTRL_EXT_CLR = 5;
  localparam int unsigned CPC_CTRL_W = 5;

  // Flag register fields: three bits per point, then the external request flag.
  localparam int unsigned CPC_FLG_BELOW = 0;
  localparam int unsigned CPC_FLG_MATCH = 1;
  localparam int unsigned CPC_FLG_ABOVE = 2;
  localparam int unsigned CPC_FLG_STRIDE = 3;
  localparam int unsigned CPC_FLG_EXT = 6;

  localparam logic [CPC_CTRL_W-1:0] CPC_CTRL_RST = 5'h00;
  localparam logic [31:0] CPC_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] CPC_IRQ_RST = 2'h0;

  typedef struct packed {
    logic below;
    logic match;
    logic above;
  } cpc_flags_s;

  typedef struct packed {
    logic [CPC_ADDR_W-1:0] addr;
    logic [CPC_DATA_W-1:0] wdata;
    logic we;
    logic re;
  } cpc_bus_s;
endpackage : cpc_pkg

// ---- core/cpc_point.sv ----
// One comparison point: below, match and above flags and the gated match pin.
// Assumes count, compare value and commands come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cpc_point (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic signed [cpc_pkg::CPC_CNT_W-1:0] count,
  input wire logic signed [cpc_pkg::CPC_CNT_W-1:0] cmp,
  input wire logic reset_cmd,
  input wire logic out_en,
  output cpc_pkg::cpc_flags_s flags,
  output logic match_pin,
  output logic match_rise
);
  import cpc_pkg::*;

  logic match_q;
  logic match_d;
  logic equal;
  logic pin_q;

  assign equal = (count == cmp);

  // The match flag latches and stays set after the count moves on, so a second
  // equality cannot produce a fresh edge until the reset command is pulsed.
  always_comb begin
    match_d = match_q;
    if (reset_cmd) begin
      match_d = 1'b0;
    end else if (equal) begin
      match_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= match_d & out_en;
    end
  end

  assign flags.below = (count < cmp);
  assign flags.above = (count > cmp);
  assign flags.match = match_q;
  assign match_pin = pin_q;
  assign match_rise = match_d & ~match_q;

  property p_below;
    @(posedge sys_clk) disable iff (rst) flags.below == (count < cmp);
  endproperty
  a_below: assert property (p_below) else $error("below flag wrong");

  property p_not_below;
    @(posedge sys_clk) disable iff (rst) (count >= cmp) |-> !flags.below;
  endproperty
  a_not_below: assert property (p_not_below) else $error("below flag set at or over");

  property p_above;
    @(posedge sys_clk) disable iff (rst) (count > cmp) |-> flags.above && !flags.below;
  endproperty
  a_above: assert property (p_above) else $error("above flag wrong");

  property p_one_of_three;
    @(posedge sys_clk) disable iff (rst) $onehot({flags.below, equal, flags.above});
  endproperty
  a_one_of_three: assert property (p_one_of_three) else $error("not exactly one");

  property p_match_set;
    @(posedge sys_clk) disable iff (rst) (equal && !reset_cmd) |=> match_q;
  endproperty
  a_match_set: assert property (p_match_set) else $error("match not set");

  property p_match_reset;
    @(posedge sys_clk) disable iff (rst) reset_cmd |=> !match_q ##0 !match_pin;
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("reset ignored");

  property p_rearm;
    @(posedge sys_clk) disable iff (rst)
      ($fell(reset_cmd) && equal) |=> match_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no rearm on release");

  property p_hold;
    @(posedge sys_clk) disable iff (rst) (match_q && !reset_cmd) |-> !match_rise ##1 match_q;
  endproperty
  a_hold: assert property (p_hold) else $error("match lost or refired");

  property p_pin_gate;
    @(posedge sys_clk) disable iff (rst) match_pin |-> $past(out_en) && match_q;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin not gated");

  c_reset_while_equal: cover property (@(posedge sys_clk) disable iff (rst)
    equal && match_q ##1 reset_cmd && equal ##1 !reset_cmd && equal);
endmodule : cpc_point
`default_nettype wire

// ---- core/cpc_counter.sv ----
// Counter channel with program preset and two compare points behind a strobe port.
// Assumes count and external request pins are asynchronous; the bus is on sys_clk.
//
// Notes on behaviour
// - Preset value write stores, count untouched.
// - Preset command rising edge loads the count.
// - Preset load ignores count enable state.
// - Compare write accepts any value.
// - Two independent points with own reset commands.
// - Below flag while count under compare.
// - Below flag clears at or above compare.
// - Equality sets match flag and output.
// - Output enable gates both match pins.
// - Reset command clears match flag and pin.
// - Reset clears even during ongoing equality.
// - Release during equality sets match again.
// - Above flag while count over compare.
// - Only new match edges signal; rearm needed.
// - Count is signed 32-bit full range.
// - External request flag blocks every preset.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cpc_counter (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [cpc_pkg::CPC_ADDR_W-1:0] bus_addr,
  input wire logic [cpc_pkg::CPC_DATA_W-1:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [cpc_pkg::CPC_DATA_W-1:0] bus_rdata,
  input wire logic count_up_pin,
  input wire logic count_down_pin,
  input wire logic ext_preset_request_pin,
  output logic [cpc_pkg::CPC_NPOINTS-1:0] match_out,
  output logic irq
);
  import cpc_pkg::*;

  cpc_bus_s bus;
  assign bus.addr = bus_addr;
  assign bus.wdata = bus_wdata;
  assign bus.we = bus_we;
  assign bus.re = bus_re;

  function automatic logic hit_write(input cpc_bus_s b, input logic [CPC_ADDR_W-1:0] ofs);
    hit_write = b.we && (b.addr == ofs);
  endfunction : hit_write

  // Control register.
  logic [CPC_CTRL_W-1:0] ctrl_q;
  logic count_enable_cmd;
  logic program_preset_cmd;
  logic match_output_enable_cmd;
  logic [CPC_NPOINTS-1:0] match_reset_cmd;
  logic ext_clr_pulse;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CPC_CTRL_RST;
    end else if (hit_write(bus, CPC_OFS_CTRL)) begin
      ctrl_q <= bus.wdata[CPC_CTRL_W-1:0];
    end
  end

  assign count_enable_cmd = ctrl_q[CPC_CTRL_COUNT_EN];
  assign program_preset_cmd = ctrl_q[CPC_CTRL_PRESET];
  assign match_output_enable_cmd = ctrl_q[CPC_CTRL_OUT_EN];
  assign match_reset_cmd = {ctrl_q[CPC_CTRL_RST2], ctrl_q[CPC_CTRL_RST1]};
  // The request clear is a write-one pulse, not a stored bit.
  assign ext_clr_pulse = hit_write(bus, CPC_OFS_CTRL) && bus.wdata[CPC_CTRL_EXT_CLR];

  // Preset holding value and compare points.
  logic signed [CPC_CNT_W-1:0] preset_q;
  logic signed [CPC_CNT_W-1:0] cmp_q [CPC_NPOINTS];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preset_q <= CPC_WORD_RST;
    end else if (hit_write(bus, CPC_OFS_PRESET)) begin
      preset_q <= bus.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmp_q[0] <= CPC_WORD_RST;
      cmp_q[1] <= CPC_WORD_RST;
    end else begin
      if (hit_write(bus, CPC_OFS_CMP1)) begin
        cmp_q[0] <= bus.wdata;
      end
      if (hit_write(bus, CPC_OFS_CMP2)) begin
        cmp_q[1] <= bus.wdata;
      end
    end
  end

  // Pin synchronisers; edges are taken between the second and third stages.
  logic [2:0] up_sync_q;
  logic [2:0] down_sync_q;
  logic [2:0] ext_sync_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      up_sync_q <= 3'h0;
      down_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
    end else begin
      up_sync_q <= {up_sync_q[1:0], count_up_pin};
      down_sync_q <= {down_sync_q[1:0], count_down_pin};
      ext_sync_q <= {ext_sync_q[1:0], ext_preset_request_pin};
    end
  end

  logic up_step;
  logic down_step;
  logic ext_rise;
  assign up_step = up_sync_q[1] & ~up_sync_q[2];
  assign down_step = down_sync_q[1] & ~down_sync_q[2];
  assign ext_rise = ext_sync_q[1] & ~ext_sync_q[2];

  // External preset request flag; a new request wins over a clear in the same cycle.
  logic ext_preset_request_flag_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_preset_request_flag_q <= 1'b0;
    end else if (ext_rise) begin
      ext_preset_request_flag_q <= 1'b1;
    end else if (ext_clr_pulse) begin
      ext_preset_request_flag_q <= 1'b0;
    end
  end

  // Program preset edge detection.
  logic preset_cmd_prev_q;
  logic preset_load;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preset_cmd_prev_q <= 1'b0;
    end else begin
      preset_cmd_prev_q <= program_preset_cmd;
    end
  end

  assign preset_load = program_preset_cmd && !preset_cmd_prev_q
                       && !ext_preset_request_flag_q;

  // Current count. Simultaneous up and down steps cancel. The count wraps at the
  // signed limits because linear and ring limit handling is not part of this block.
  logic signed [CPC_CNT_W-1:0] count_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= CPC_WORD_RST;
    end else if (preset_load) begin
      count_q <= preset_q;
    end else if (count_enable_cmd && (up_step != down_step)) begin
      count_q <= up_step ? count_q + 32'sd1 : count_q - 32'sd1;
    end
  end

  // Compare points.
  cpc_flags_s flags [CPC_NPOINTS];
  logic [CPC_NPOINTS-1:0] match_rise;

  for (genvar i = 0; i < CPC_NPOINTS; i++) begin : g_point
    cpc_point u_point (
      .sys_clk(sys_clk),
      .rst(rst),
      .count(count_q),
      .cmp(cmp_q[i]),
      .reset_cmd(match_reset_cmd[i]),
      .out_en(match_output_enable_cmd),
      .flags(flags[i]),
      .match_pin(match_out[i]),
      .match_rise(match_rise[i])
    );
  end

  // Interrupt status: sticky match events, cleared by reading; set wins.
  logic [CPC_NPOINTS-1:0] irq_stat_q;
  logic [CPC_NPOINTS-1:0] irq_mask_q;
  logic stat_read;
  assign stat_read = bus.re && (bus.addr == CPC_OFS_IRQ_STAT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_q <= CPC_IRQ_RST;
    end else begin
      irq_stat_q <= (stat_read ? CPC_IRQ_RST : irq_stat_q) | match_rise;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask_q <= CPC_IRQ_RST;
    end else if (hit_write(bus, CPC_OFS_IRQ_MASK)) begin
      irq_mask_q <= bus.wdata[CPC_NPOINTS-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read data, valid only in the cycle after the read strobe.
  logic [CPC_DATA_W-1:0] rdata_d;
  logic [CPC_DATA_W-1:0] rdata_q;

  always_comb begin
    rdata_d = CPC_WORD_RST;
    case (bus.addr)
      CPC_OFS_CTRL: rdata_d[CPC_CTRL_W-1:0] = ctrl_q;
      CPC_OFS_PRESET: rdata_d = preset_q;
      CPC_OFS_CMP1: rdata_d = cmp_q[0];
      CPC_OFS_CMP2: rdata_d = cmp_q[1];
      CPC_OFS_COUNT_LOW: rdata_d[15:0] = count_q[15:0];
      CPC_OFS_COUNT_HIGH: rdata_d[15:0] = count_q[31:16];
      CPC_OFS_FLAGS: begin
        rdata_d[CPC_FLG_BELOW] = flags[0].below;
        rdata_d[CPC_FLG_MATCH] = flags[0].match;
        rdata_d[CPC_FLG_ABOVE] = flags[0].above;
        rdata_d[CPC_FLG_STRIDE+CPC_FLG_BELOW] = flags[1].below;
        rdata_d[CPC_FLG_STRIDE+CPC_FLG_MATCH] = flags[1].match;
        rdata_d[CPC_FLG_STRIDE+CPC_FLG_ABOVE] = flags[1].above;
        rdata_d[CPC_FLG_EXT] = ext_preset_request_flag_q;
      end
      CPC_OFS_IRQ_STAT: rdata_d[CPC_NPOINTS-1:0] = irq_stat_q;
      CPC_OFS_IRQ_MASK: rdata_d[CPC_NPOINTS-1:0] = irq_mask_q;
      default: rdata_d = CPC_WORD_RST;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= CPC_WORD_RST;
    end else if (bus.re) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= CPC_WORD_RST;
    end
  end

  assign bus_rdata = rdata_q;

  property p_preset_load;
    @(posedge sys_clk) disable iff (rst)
      (program_preset_cmd && !preset_cmd_prev_q && !ext_preset_request_flag_q)
      |=> count_q == $past(preset_q);
  endproperty
  a_preset_load: assert property (p_preset_load) else $error("preset not loaded");

  property p_preset_any_enable;
    @(posedge sys_clk) disable iff (rst)
      (!count_enable_cmd && $rose(program_preset_cmd) && !ext_preset_request_flag_q)
      |=> count_q == $past(preset_q);
  endproperty
  a_preset_any_enable: assert property (p_preset_any_enable) else $error("preset gated");

  property p_preset_store_only;
    @(posedge sys_clk) disable iff (rst)
      (hit_write(bus, CPC_OFS_PRESET) && !preset_load && !count_enable_cmd)
      |=> preset_q == $past(bus.wdata) && $stable(count_q);
  endproperty
  a_preset_store_only: assert property (p_preset_store_only) else $error("preset write bad");

  property p_cmp_write;
    @(posedge sys_clk) disable iff (rst)
      hit_write(bus, CPC_OFS_CMP2) |=> cmp_q[1] == $past(bus.wdata);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("compare write lost");

  property p_ext_block;
    @(posedge sys_clk) disable iff (rst)
      (ext_preset_request_flag_q && !count_enable_cmd) |=> $stable(count_q);
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("preset while blocked");

  property p_count_step;
    @(posedge sys_clk) disable iff (rst)
      (count_enable_cmd && up_step && !down_step && !preset_load)
      |=> count_q == $past(count_q) + 32'sd1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_points_independent;
    @(posedge sys_clk) disable iff (rst)
      (match_reset_cmd == 2'h1 && flags[1].match) |=> flags[1].match && !flags[0].match;
  endproperty
  a_points_independent: assert property (p_points_independent) else $error("points coupled");

  property p_irq_level;
    @(posedge sys_clk) disable iff (rst) match_rise[0] && irq_mask_q[0] |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missing");

  property p_preset_counting;
    @(posedge sys_clk) disable iff (rst)
      (count_enable_cmd && preset_load) |=> count_q == $past(preset_q);
  endproperty
  a_preset_counting: assert property (p_preset_counting) else $error("preset lost");

  property p_count_down;
    @(posedge sys_clk) disable iff (rst)
      (count_enable_cmd && down_step && !up_step && !preset_load)
      |=> count_q == $past(count_q) - 32'sd1;
  endproperty
  a_count_down: assert property (p_count_down) else $error("count down wrong");

  property p_count_hold;
    @(posedge sys_clk) disable iff (rst)
      (!count_enable_cmd && !preset_load) |=> $stable(count_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved while disabled");

  property p_ext_set;
    @(posedge sys_clk) disable iff (rst) ext_rise |=> ext_preset_request_flag_q;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("request flag not set");

  property p_ext_sticky;
    @(posedge sys_clk) disable iff (rst)
      (ext_preset_request_flag_q && !ext_clr_pulse) |=> ext_preset_request_flag_q;
  endproperty
  a_ext_sticky: assert property (p_ext_sticky) else $error("request flag dropped");

  property p_ext_clear;
    @(posedge sys_clk) disable iff (rst)
      (ext_clr_pulse && !ext_rise) |=> !ext_preset_request_flag_q;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("request flag kept");

  property p_out_gate;
    @(posedge sys_clk) disable iff (rst) !match_output_enable_cmd |=> match_out == 2'h0;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("pins not gated");

  property p_stat_set_wins;
    @(posedge sys_clk) disable iff (rst) (stat_read && match_rise[0]) |=> irq_stat_q[0];
  endproperty
  a_stat_set_wins: assert property (p_stat_set_wins) else $error("event lost on read");

  property p_stat_clear;
    @(posedge sys_clk) disable iff (rst)
      (stat_read && match_rise == CPC_IRQ_RST) |=> irq_stat_q == CPC_IRQ_RST;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (rst) !bus.re |=> bus_rdata == CPC_WORD_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  c_preset: cover property (@(posedge sys_clk) disable iff (rst) preset_load);
  c_blocked: cover property (@(posedge sys_clk) disable iff (rst)
    ext_preset_request_flag_q && $rose(program_preset_cmd));
  c_pin: cover property (@(posedge sys_clk) disable iff (rst) match_out[0] ##1 !match_out[0]);
  c_both: cover property (@(posedge sys_clk) disable iff (rst) &match_out);
endmodule : cpc_counter
`default_nettype wire

// ---- sim/cpc_counter_test.sv ----
// Self-checking bench for the counter preset and compare channel.
// Assumes the cpc_counter top and cpc_pkg; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module cpc_counter_test;
  import cpc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [CPC_ADDR_W-1:0] bus_addr = 8'h00;
  logic [CPC_DATA_W-1:0] bus_wdata = 32'h0000_0000;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic [CPC_DATA_W-1:0] bus_rdata;
  logic count_up_pin = 1'b0;
  logic count_down_pin = 1'b0;
  logic ext_preset_request_pin = 1'b0;
  logic [CPC_NPOINTS-1:0] match_out;
  logic irq;
  integer seed = 41819;
  int fails = 0;
  int tests_run = 0;
  logic [31:0] rdat, cnt, c1, c2, v, p, ce;
  int offs [6] = '{-1, 0, 1, 2, 3, 5};
  logic [31:0] ptab [4] = '{32'h7fff_ffff, 32'h8000_0000, 32'h0000_0001, 32'hffff_ffff};

  always #20 sys_clk = ~sys_clk;

  cpc_counter i_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_we(bus_we),
    .bus_re(bus_re),
    .bus_rdata(bus_rdata),
    .count_up_pin(count_up_pin),
    .count_down_pin(count_down_pin),
    .ext_preset_request_pin(ext_preset_request_pin),
    .match_out(match_out),
    .irq(irq)
  );

  // Per point: {above, match, below}; match reads as equality because every
  // compare step holds the match resets across the load and then releases them.
  function automatic logic [31:0] exp_flags(input logic signed [31:0] cv,
      input logic signed [31:0] k1, input logic signed [31:0] k2);
    return {26'h0, cv > k2, cv == k2, cv < k2, cv > k1, cv == k1, cv < k1};
  endfunction : exp_flags

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge sys_clk);
    bus_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge sys_clk);
    bus_re <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic rd_count(output logic [31:0] c);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(CPC_OFS_COUNT_LOW, lo);
    rd(CPC_OFS_COUNT_HIGH, hi);
    c = {hi[15:0], lo[15:0]};
  endtask : rd_count

  // The preset command bit must fall again before the next load can rise.
  task automatic load(input logic [31:0] val, input logic [31:0] base);
    wr(CPC_OFS_PRESET, val);
    wr(CPC_OFS_CTRL, base);
    wr(CPC_OFS_CTRL, base | 32'h2);
    wr(CPC_OFS_CTRL, base);
  endtask : load

  task automatic pulse(input logic dn, input int n);
    repeat (n) begin
      if (dn) count_down_pin <= 1'b1;
      else count_up_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      count_down_pin <= 1'b0;
      count_up_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  task automatic summarize();
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    // Count and both compare values start at zero, so both points show equality.
    rd(CPC_OFS_FLAGS, rdat);
    `CHK("reset flags", 32'h0000_0012, rdat)
    rd(CPC_OFS_IRQ_STAT, rdat);
    `CHK("reset irq status", 32'h0000_0003, rdat)
    `CHK("irq masked", 1'b0, irq)
    rd(8'h40, rdat);
    `CHK("unmapped read", 32'h0000_0000, rdat)
    v = $random(seed);
    wr(CPC_OFS_PRESET, v);
    rd_count(cnt);
    `CHK("count after preset write", 32'h0000_0000, cnt)
    rd(CPC_OFS_PRESET, rdat);
    `CHK("preset setting", v, rdat)
    for (int i = 0; i < 4; i++) begin
      ce = i % 2;
      load(ptab[i], ce);
      rd_count(cnt);
      `CHK("count after load", ptab[i], cnt)
    end
    c1 = $signed($random(seed)) / 4;
    c2 = c1 + 2;
    wr(CPC_OFS_CMP1, c1);
    wr(CPC_OFS_CMP2, c2);
    rd(CPC_OFS_CMP1, rdat);
    `CHK("compare one", c1, rdat)
    rd(CPC_OFS_CMP2, rdat);
    `CHK("compare two", c2, rdat)
    foreach (offs[i]) begin
      v = c1 + offs[i];
      ce = $random(seed) & 1;
      load(v, 32'h1c | ce);
      wr(CPC_OFS_CTRL, 32'h04 | ce);
      rd(CPC_OFS_FLAGS, rdat);
      `CHK("flags", exp_flags(v, c1, c2), rdat)
      `CHK("match pins", {v == c2, v == c1}, match_out)
    end
    wr(CPC_OFS_IRQ_MASK, 32'h1);
    load(c1, 32'h1c);
    rd(CPC_OFS_IRQ_STAT, rdat);
    wr(CPC_OFS_CTRL, 32'h04);
    repeat (2) @(posedge sys_clk);
    `CHK("irq on match", 1'b1, irq)
    `CHK("pin on match", 2'b01, match_out)
    rd(CPC_OFS_IRQ_STAT, rdat);
    `CHK("irq status", 32'h0000_0001, rdat)
    `CHK("irq after clear", 1'b0, irq)
    repeat (4) @(posedge sys_clk);
    rd(CPC_OFS_IRQ_STAT, rdat);
    `CHK("no fresh match", 32'h0000_0000, rdat)
    wr(CPC_OFS_CTRL, 32'h00);
    repeat (2) @(posedge sys_clk);
    `CHK("pins gated", 2'b00, match_out)
    rd(CPC_OFS_FLAGS, rdat);
    `CHK("flag kept while gated", 1'b1, rdat[1])
    wr(CPC_OFS_CTRL, 32'h0c);
    repeat (2) @(posedge sys_clk);
    `CHK("pin under reset", 2'b00, match_out)
    rd(CPC_OFS_FLAGS, rdat);
    `CHK("flag under reset", 1'b0, rdat[1])
    wr(CPC_OFS_CTRL, 32'h04);
    repeat (2) @(posedge sys_clk);
    `CHK("pin after release", 2'b01, match_out)
    `CHK("irq after rearm", 1'b1, irq)
    wr(CPC_OFS_IRQ_MASK, 32'h0);
    @(posedge sys_clk);
    `CHK("irq masked off", 1'b0, irq)
    rd(CPC_OFS_IRQ_STAT, rdat);
    `CHK("irq status rearm", 32'h0000_0001, rdat)
    ext_preset_request_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    ext_preset_request_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(CPC_OFS_FLAGS, rdat);
    `CHK("external flag set", 1'b1, rdat[CPC_FLG_EXT])
    p = $random(seed);
    load(p, 32'h1c);
    rd_count(cnt);
    `CHK("preset refused", c1, cnt)
    wr(CPC_OFS_CTRL, 32'h3c);
    rd(CPC_OFS_FLAGS, rdat);
    `CHK("external flag cleared", 1'b0, rdat[CPC_FLG_EXT])
    load(p, 32'h1c);
    rd_count(cnt);
    `CHK("preset after clear", p, cnt)
    // Point one is held in reset while point two alone matches.
    load(c2, 32'h0c);
    repeat (2) @(posedge sys_clk);
    `CHK("point two alone", 2'b10, match_out)
    // Start just below zero so counting can cross the half-word boundary either way.
    load(32'hffff_fffe, 32'h1d);
    v = ($random(seed) & 3) + 1;
    pulse(1'b0, v);
    rd_count(cnt);
    `CHK("count up", 32'hffff_fffe + v, cnt)
    p = ($random(seed) & 3) + 1;
    pulse(1'b1, p);
    rd_count(cnt);
    `CHK("count down", 32'hffff_fffe + v - p, cnt)
    summarize();
  end
endmodule : cpc_counter_test
`undef CHK
`default_nettype wire
